//--- core/line_monitor.sv
// Purpose: Line state detector and transformer circuit monitor behind APB.
// Assumes: Magnitudes come from same-clock logic, unit 1/256 percent of nominal.
// Notes:   Timers count a 1 ms tick made from pclk.
// Function
// RULE1: Inhibit input asserted disables line state detection.
// RULE2: Per phase voltage start flag when magnitude exceeds voltage limit.
// RULE3: Per phase current start flag when magnitude exceeds current limit.
// RULE4: Dead flag only when all voltages and currents are low.
// RULE5: Live flag when all three phase voltages are high.
// RULE6: Live flag is its own output beside the dead flag.
// RULE7: Detector raises no events of its own.
// RULE8: Exactly three failure modes: zero, negative and special.
// RULE9: Zero mode: residual voltage high and residual current low.
// RULE10: Negative mode: negative voltage high and negative current low.
// RULE11: Special: residual voltage high, residual and negative current low.
// RULE12: Arm only after live flag held 200 ms.
// RULE13: Dead flag disarms supervision.
// RULE14: Armed, fault flag rises after condition holds 4 ms.
// RULE15: Supervision works only while detector on and not inhibited.
// RULE16: Condition gone while live, fault flag drops after 200 ms.
// RULE17: Dead rise after 100 ms of fault latches the fault flag.
// RULE18: Dead rise before 100 ms of fault clears the fault flag.
// RULE19: Voltage threshold 10 to 100 percent, default 60.
// RULE20: Current threshold 2 to 100 percent, default 10.
// RULE21: Operation on/off setting, default off.
// RULE22: Sequence thresholds and mode are software settings.
// RULE23: Timers count a periodic tick and restart when condition drops.
// RULE24: Comparators release at 0.95 of pick-up level.
//
// The implementer's own choices: the APB register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "line_monitor_regs.svh"
module line_monitor
    import line_monitor_pkg::*;
#(
    parameter int TICK_CYCLES = `TICK_NS / `CLK_NS
) (
    input  wire logic        pclk,          // Clock, 10 MHz.
    input  wire logic        presetn,       // Asynchronous reset, low.
    input  wire logic        psel,          // APB select.
    input  wire logic        penable,       // APB access phase.
    input  wire logic        pwrite,        // APB write.
    input  wire logic [7:0]  paddr,         // APB byte address.
    input  wire logic [31:0] pwdata,        // APB write data.
    output logic             pready,        // APB ready.
    output logic [31:0]      prdata,        // APB read data.
    output logic             pslverr,       // APB error, unmapped address, read or write.
    input  wire logic [15:0] phase1_volt,   // Phase 1 voltage magnitude.
    input  wire logic [15:0] phase2_volt,   // Phase 2 voltage magnitude.
    input  wire logic [15:0] phase3_volt,   // Phase 3 voltage magnitude.
    input  wire logic [15:0] phase1_curr,   // Phase 1 current magnitude.
    input  wire logic [15:0] phase2_curr,   // Phase 2 current magnitude.
    input  wire logic [15:0] phase3_curr,   // Phase 3 current magnitude.
    input  wire logic [15:0] residual_voltage,     // Residual voltage.
    input  wire logic [15:0] residual_current,     // Residual current.
    input  wire logic [15:0] negative_seq_voltage, // Negative seq. voltage.
    input  wire logic [15:0] negative_seq_current, // Negative seq. current.
    input  wire logic        line_state_inhibit,   // Detector inhibit.
    output logic             phase1_voltage_present, // Phase 1 V start.
    output logic             phase2_voltage_present, // Phase 2 V start.
    output logic             phase3_voltage_present, // Phase 3 V start.
    output logic             phase1_current_present, // Phase 1 I start.
    output logic             phase2_current_present, // Phase 2 I start.
    output logic             phase3_current_present, // Phase 3 I start.
    output logic             line_dead_flag,         // Dead line.
    output logic             line_live_flag,         // Live line.
    output logic             transformer_fault_flag  // Circuit failure.
);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------

    // Comparator with release at 19/20 of the pick-up level.
    function automatic logic hyst(input logic [15:0] mag,
                                  input logic [7:0]  pct,
                                  input logic        prev);
        logic [20:0] m20;
        logic [20:0] t19;
        m20 = 21'(mag) * `DROP_NUM;
        t19 = 21'({pct, 8'h00}) * `DROP_DEN;
        if (mag > {pct, 8'h00})
            hyst = 1'b1;
        else if (prev && (m20 > t19))                       // [RULE24]
            hyst = 1'b1;
        else
            hyst = 1'b0;
    endfunction

    // Clamp a percentage into its settable range.
    function automatic logic [7:0] clamp(input logic [7:0] v,
                                         input logic [7:0] lo);
        if (v < lo)
            clamp = lo;
        else if (v > `PCT_MAX)
            clamp = `PCT_MAX;
        else
            clamp = v;
    endfunction

    // Saturating millisecond timer, cleared when its condition drops.
    function automatic logic [7:0] ms_tmr(input logic [7:0] t,
                                          input logic       cond,
                                          input logic       tick);
        if (!cond)
            ms_tmr = 8'h00;                                 // [RULE23]
        else if (tick && (t != 8'hFF))
            ms_tmr = t + 8'h01;                             // [RULE23]
        else
            ms_tmr = t;
    endfunction

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------

    mon_state_t s_reg;
    mon_state_t s_next;
    logic       enable;
    logic       tick;
    logic       cond;
    logic       dead_rise;
    logic       wr_en;
    logic       rd_setup;
    logic [3:0] seq_n;

    // Detector and supervision run only when on and not inhibited.
    assign enable = s_reg.op_on && !line_state_inhibit;     // [RULE1] [RULE15]
    assign tick = (s_reg.tick_cnt == 14'(TICK_CYCLES - 1));
    assign wr_en = psel && penable && pwrite;
    assign rd_setup = psel && !penable;

    // Failure condition of the selected mode from the sequence flags.
    always_comb begin
        case (s_reg.mode)
            MODE_ZERO:    cond = s_reg.seq_st[0] && !s_reg.seq_st[1]; // [RULE9]
            MODE_NEG:     cond = s_reg.seq_st[2] && !s_reg.seq_st[3]; // [RULE10]
            MODE_SPECIAL: cond = s_reg.seq_st[0] && !s_reg.seq_st[1]
                                 && !s_reg.seq_st[3];              // [RULE11]
            default:      cond = 1'b0;
        endcase
    end

    // Sequence comparators, thresholds from the sequence register.
    assign seq_n = {hyst(negative_seq_current, s_reg.seq_thr[31:24], s_reg.seq_st[3]),
                    hyst(negative_seq_voltage, s_reg.seq_thr[23:16], s_reg.seq_st[2]),
                    hyst(residual_current, s_reg.seq_thr[15:8], s_reg.seq_st[1]),
                    hyst(residual_voltage, s_reg.seq_thr[7:0], s_reg.seq_st[0])};

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------

    always_comb begin
        logic dead_n;
        logic live_n;
        dead_n = 1'b0;
        live_n = 1'b0;
        s_next = s_reg;
        // Millisecond tick.
        s_next.tick_cnt = tick ? 14'h0000 : s_reg.tick_cnt + 14'h0001;
        // Register writes; an out-of-range mode is refused.
        if (wr_en) begin
            case (paddr)
                `CTRL_OFS: begin
                    s_next.op_on = pwdata[`CTRL_ON_BIT];                 // [RULE21]
                    if (pwdata[`CTRL_MODE_LSB +: 2] != 2'h3)
                        s_next.mode = fail_mode_t'(pwdata[`CTRL_MODE_LSB +: 2]); // [RULE8]
                end
                `LINE_THR_OFS: begin
                    s_next.volt_pct = clamp(pwdata[7:0], `VOLT_PCT_MIN);  // [RULE19]
                    s_next.curr_pct = clamp(pwdata[15:8], `CURR_PCT_MIN); // [RULE20]
                end
                `SEQ_THR_OFS: s_next.seq_thr = pwdata;                    // [RULE22]
                default: ;
            endcase
        end
        // Read data is captured in the setup cycle.
        s_next.slverr = 1'b0;
        if (rd_setup) begin
            case (paddr)
                `CTRL_OFS:     s_next.rdata = {29'h0, s_reg.mode, s_reg.op_on};
                `LINE_THR_OFS: s_next.rdata = {16'h0, s_reg.curr_pct, s_reg.volt_pct};
                `SEQ_THR_OFS:  s_next.rdata = s_reg.seq_thr;
                `STATUS_OFS:   s_next.rdata = {20'h00000, s_reg.latched, s_reg.st,
                                               s_reg.live, s_reg.dead,
                                               s_reg.i_st, s_reg.v_st};
                default: begin
                    s_next.rdata = 32'h00000000;
                    s_next.slverr = 1'b1;
                end
            endcase
        end
        if (!enable) begin
            // Disabled: all flags and supervision cleared.
            s_next.v_st = 3'h0;                                 // [RULE1]
            s_next.i_st = 3'h0;
            s_next.seq_st = 4'h0;
            s_next.dead = 1'b0;
            s_next.live = 1'b0;
            s_next.live_ms = 8'h00;
            s_next.cond_ms = 8'h00;
            s_next.rel_ms = 8'h00;
            s_next.age_ms = 8'h00;
            s_next.latched = 1'b0;
            s_next.st = SUP_OFF;                                // [RULE15]
        end else begin
            // Phase start flags with hysteresis.
            s_next.v_st = {hyst(phase3_volt, s_reg.volt_pct, s_reg.v_st[2]),
                           hyst(phase2_volt, s_reg.volt_pct, s_reg.v_st[1]),
                           hyst(phase1_volt, s_reg.volt_pct, s_reg.v_st[0])}; // [RULE2]
            s_next.i_st = {hyst(phase3_curr, s_reg.curr_pct, s_reg.i_st[2]),
                           hyst(phase2_curr, s_reg.curr_pct, s_reg.i_st[1]),
                           hyst(phase1_curr, s_reg.curr_pct, s_reg.i_st[0])}; // [RULE3]
            s_next.seq_st = seq_n;
            dead_n = (s_reg.v_st == 3'h0) && (s_reg.i_st == 3'h0);  // [RULE4]
            live_n = (s_reg.v_st == 3'h7);                          // [RULE5]
            s_next.dead = dead_n;
            s_next.live = live_n;
            s_next.live_ms = ms_tmr(s_reg.live_ms, s_reg.live, tick);
            s_next.cond_ms = ms_tmr(s_reg.cond_ms, cond, tick);
            case (s_reg.st)
                SUP_OFF: begin
                    if (s_reg.live && !s_reg.dead && s_reg.live_ms >= `LIVE_ARM_MS)
                        s_next.st = SUP_ARMED;                      // [RULE12]
                end
                SUP_ARMED: begin
                    if (s_reg.dead)
                        s_next.st = SUP_OFF;                        // [RULE13]
                    else if (cond && s_reg.cond_ms >= `FAIL_QUAL_MS) begin
                        s_next.st = SUP_FAULT;                      // [RULE14]
                        s_next.age_ms = 8'h00;
                        s_next.rel_ms = 8'h00;
                    end
                end
                SUP_FAULT: begin
                    s_next.age_ms = ms_tmr(s_reg.age_ms, 1'b1, tick);
                    s_next.rel_ms = ms_tmr(s_reg.rel_ms, !cond && s_reg.live, tick);
                    if (dead_rise) begin
                        if (s_reg.age_ms >= `LATCH_MS)
                            s_next.latched = 1'b1;                  // [RULE17]
                        else
                            s_next.st = SUP_OFF;                    // [RULE18]
                    end else if (s_reg.rel_ms >= `RELEASE_MS) begin
                        s_next.st = SUP_ARMED;                      // [RULE16]
                        s_next.latched = 1'b0;
                    end
                end
                default: s_next.st = SUP_OFF;
            endcase
        end
    end

    // Dead flag rising edge, taken from the registered flag.
    logic dead_prev_reg;
    assign dead_rise = s_reg.dead && !dead_prev_reg;

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------

    // State register; reset loads the default settings and the off state.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg <= '0;
            s_reg.mode <= MODE_ZERO;
            s_reg.volt_pct <= `VOLT_PCT_RST;
            s_reg.curr_pct <= `CURR_PCT_RST;
            s_reg.seq_thr <= `SEQ_THR_RST;
            s_reg.st <= SUP_OFF;
            dead_prev_reg <= 1'b0;
        end else begin
            s_reg <= s_next;
            dead_prev_reg <= s_reg.dead;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------

    // Zero-wait APB answers; flags are plain levels, no events.
    assign pready = 1'b1;
    assign prdata = s_reg.rdata;
    assign pslverr = s_reg.slverr && psel && penable;
    assign {phase3_voltage_present, phase2_voltage_present,
            phase1_voltage_present} = s_reg.v_st;
    assign {phase3_current_present, phase2_current_present,
            phase1_current_present} = s_reg.i_st;
    assign line_dead_flag = s_reg.dead;
    assign line_live_flag = s_reg.live;                     // [RULE6] [RULE7]
    assign transformer_fault_flag = (s_reg.st == SUP_FAULT);

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------

    property p_inhibit;
        @(posedge pclk) disable iff (!presetn)
        line_state_inhibit |=> !line_dead_flag && !line_live_flag;
    endproperty
    a_inhibit: assert property (p_inhibit) else $error("flags under inhibit"); // [RULE1]

    property p_dead_all_low;
        @(posedge pclk) disable iff (!presetn)
        line_dead_flag |-> $past(s_reg.v_st) == 3'h0 && $past(s_reg.i_st) == 3'h0;
    endproperty
    a_dead_all_low: assert property (p_dead_all_low) else $error("bad dead"); // [RULE4]

    property p_live_all_high;
        @(posedge pclk) disable iff (!presetn)
        line_live_flag |-> $past(s_reg.v_st) == 3'h7;
    endproperty
    a_live_all_high: assert property (p_live_all_high) else $error("bad live"); // [RULE5]

    property p_arm_wait;
        @(posedge pclk) disable iff (!presetn)
        $rose(s_reg.st == SUP_ARMED) && $past(s_reg.st) == SUP_OFF
        |-> $past(s_reg.live_ms) >= `LIVE_ARM_MS;
    endproperty
    a_arm_wait: assert property (p_arm_wait) else $error("early arm"); // [RULE12]

    property p_dead_disarm;
        @(posedge pclk) disable iff (!presetn)
        s_reg.st == SUP_ARMED && s_reg.dead && enable |=> s_reg.st == SUP_OFF;
    endproperty
    a_dead_disarm: assert property (p_dead_disarm) else $error("no disarm"); // [RULE13]

    property p_fail_qual;
        @(posedge pclk) disable iff (!presetn)
        $rose(transformer_fault_flag) |-> $past(s_reg.cond_ms) >= `FAIL_QUAL_MS;
    endproperty
    a_fail_qual: assert property (p_fail_qual) else $error("early fault"); // [RULE14]

    property p_disable_off;
        @(posedge pclk) disable iff (!presetn)
        !enable |=> !transformer_fault_flag;
    endproperty
    a_disable_off: assert property (p_disable_off) else $error("fault when off"); // [RULE15]

    property p_latch;
        @(posedge pclk) disable iff (!presetn)
        enable && transformer_fault_flag && dead_rise && s_reg.age_ms >= `LATCH_MS
        |=> transformer_fault_flag && s_reg.latched;
    endproperty
    a_latch: assert property (p_latch) else $error("no latch"); // [RULE17]

    property p_early_dead;
        @(posedge pclk) disable iff (!presetn)
        enable && transformer_fault_flag && dead_rise && s_reg.age_ms < `LATCH_MS
        |=> !transformer_fault_flag;
    endproperty
    a_early_dead: assert property (p_early_dead) else $error("no clear"); // [RULE18]

    property p_release;
        @(posedge pclk) disable iff (!presetn)
        $fell(transformer_fault_flag) && $past(enable) && !$past(dead_rise)
        |-> $past(s_reg.rel_ms) >= `RELEASE_MS;
    endproperty
    a_release: assert property (p_release) else $error("early release"); // [RULE16]

    property p_volt_start;
        @(posedge pclk) disable iff (!presetn)
        enable && phase1_volt > {s_reg.volt_pct, 8'h00} |=> phase1_voltage_present;
    endproperty
    a_volt_start: assert property (p_volt_start) else $error("no voltage start"); // [RULE2]

    property p_curr_start;
        @(posedge pclk) disable iff (!presetn)
        enable && phase3_curr > {s_reg.curr_pct, 8'h00} |=> phase3_current_present;
    endproperty
    a_curr_start: assert property (p_curr_start) else $error("no current start"); // [RULE3]

endmodule // line_monitor
`default_nettype wire

//--- core/line_monitor_pkg.sv
// Purpose: Types of the line monitor.
// Assumes: Nothing beyond the register header.
// Notes:   Holds types only.
package line_monitor_pkg;
    // Failure detection modes.
    typedef enum logic [1:0] {
        MODE_ZERO    = 2'h0,
        MODE_NEG     = 2'h1,
        MODE_SPECIAL = 2'h2
    } fail_mode_t;
    // Supervision states, one-hot.
    typedef enum logic [2:0] {
        SUP_OFF   = 3'b001,
        SUP_ARMED = 3'b010,
        SUP_FAULT = 3'b100
    } sup_state_t;
    // Whole state of the monitor except dead_prev_reg.
    typedef struct packed {
        logic        op_on;
        fail_mode_t  mode;
        logic [7:0]  volt_pct;
        logic [7:0]  curr_pct;
        logic [31:0] seq_thr;
        logic [2:0]  v_st;
        logic [2:0]  i_st;
        logic [3:0]  seq_st;
        logic        dead;
        logic        live;
        logic [13:0] tick_cnt;
        logic [7:0]  live_ms;
        logic [7:0]  cond_ms;
        logic [7:0]  rel_ms;
        logic [7:0]  age_ms;
        logic        latched;
        sup_state_t  st;
        logic [31:0] rdata;
        logic        slverr;
    } mon_state_t;
endpackage

//--- core/line_monitor_regs.svh
// Purpose: Offsets, field positions, reset values and timing for the line monitor.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes:   Definitions only.
`ifndef LINE_MONITOR_REGS_SVH
`define LINE_MONITOR_REGS_SVH
// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define CTRL_OFS      8'h00
`define LINE_THR_OFS  8'h04
`define SEQ_THR_OFS   8'h08
`define STATUS_OFS    8'h0C
// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define CTRL_ON_BIT   0
`define CTRL_MODE_LSB 1
`define VOLT_PCT_RST  8'h3C
`define CURR_PCT_RST  8'h0A
`define VOLT_PCT_MIN  8'h0A
`define CURR_PCT_MIN  8'h02
`define PCT_MAX       8'h64
`define SEQ_THR_RST   32'h0A140A14
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_NS        100
`define TICK_NS       1000000
`define LIVE_ARM_MS   8'hC8
`define FAIL_QUAL_MS  8'h04
`define RELEASE_MS    8'hC8
`define LATCH_MS      8'h64
`define DROP_NUM      21'h000014
`define DROP_DEN      21'h000013
`endif

//--- dv/meas_front_model.sv
// Purpose: Front end model that feeds measured magnitudes to the monitor.
// Assumes: Magnitudes in 1/256 percent of nominal, same clock as the monitor.
// Notes:   A value set by put reaches the port one clock later.
`timescale 1ns/100ps
`default_nettype none
module meas_front_model (
    input  wire logic        pclk,     // Clock.
    input  wire logic        presetn,  // Reset, active low.
    output logic      [15:0] mag [10]  // Phase V 1-3, phase I 1-3, residual V, I, negative V, I.
);
    logic [7:0] tgt [10];
    // Sets one channel in whole percent, off the sampling edge.
    task automatic put(input int k, input logic [7:0] p);
        tgt[k] <= p;
    endtask
    // Registers the targets as magnitudes; reset drives all channels to zero.
    always_ff @(posedge pclk or negedge presetn) begin
        for (int k = 0; k < 10; k++) begin
            mag[k] <= presetn ? {tgt[k], 8'h00} : 16'h0000;
        end
    end
    // Starts every channel at zero.
    initial tgt = '{default: 8'h00};
endmodule // meas_front_model
`default_nettype wire

//--- dv/tb.sv
// Purpose: Self-checking bench for the line monitor.
// Assumes: TICK_CYCLES of 10, so 1 ms is 10 clocks.
// Notes:   Magnitudes come from the front end model.
`timescale 1ns/100ps
`default_nettype none
`include "line_monitor_regs.svh"
module tb;
    logic              pclk, presetn, psel, penable, pwrite, inh, e;
    logic        [7:0] paddr;
    logic       [31:0] pwdata, d;
    wire logic         pready, pslverr;
    wire logic  [31:0] prdata;
    wire logic  [15:0] mag [10];
    wire logic   [8:0] fl;
    int                n_mismatch, num_checks;
    meas_front_model i_front (.pclk(pclk), .presetn(presetn), .mag(mag));
    line_monitor #(.TICK_CYCLES(10)) i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .phase1_volt(mag[0]),
        .phase2_volt(mag[1]), .phase3_volt(mag[2]), .phase1_curr(mag[3]),
        .phase2_curr(mag[4]), .phase3_curr(mag[5]), .residual_voltage(mag[6]),
        .residual_current(mag[7]), .negative_seq_voltage(mag[8]),
        .negative_seq_current(mag[9]), .line_state_inhibit(inh),
        .phase1_voltage_present(fl[0]), .phase2_voltage_present(fl[1]),
        .phase3_voltage_present(fl[2]), .phase1_current_present(fl[3]),
        .phase2_current_present(fl[4]), .phase3_current_present(fl[5]),
        .line_dead_flag(fl[6]), .line_live_flag(fl[7]),
        .transformer_fault_flag(fl[8]));
    // Clock of 100 ns period.
    always #50 pclk = ~pclk;
    // Compares a seen value with the expected one and counts the check and any mismatch.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // One APB transfer; read data and error are taken at the ready edge.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        d = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    // Sets all three phases to one voltage and one current percentage.
    task automatic line(input logic [7:0] v, input logic [7:0] i);
        for (int k = 0; k < 3; k++) begin
            i_front.put(k, v);
            i_front.put(k + 3, i);
        end
    endtask
    task automatic done(input string s);
        $display("test %s finished", s);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Watchdog: the sequence needs about 17000 clocks.
    initial begin
        repeat (30000) @(posedge pclk);
        n_mismatch++;
        tally_and_finish();
    end
    // Main sequence.
    initial begin
        pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 8'h00; pwdata = 32'h0; inh = 1'b0;
        cyc(4);
        presetn <= 1'b1;
        apb(0, `CTRL_OFS, 0);      check(d, 32'h0);
        apb(0, `LINE_THR_OFS, 0);  check(d, 32'h0A3C);
        apb(0, `SEQ_THR_OFS, 0);   check(d, `SEQ_THR_RST);
        apb(0, 8'h10, 0);          check(d, 32'h0); check(e, 1'b1);
        apb(1, `LINE_THR_OFS, 32'hFF05);
        apb(0, `LINE_THR_OFS, 0);  check(d, 32'h640A);
        apb(1, `LINE_THR_OFS, 32'h0A3C);
        apb(1, `SEQ_THR_OFS, 32'h0B150B15);
        apb(0, `SEQ_THR_OFS, 0);   check(d, 32'h0B150B15);
        apb(1, `STATUS_OFS, 32'hFFF);
        apb(0, `STATUS_OFS, 0);    check(d, 32'h100);
        done("registers");
        line(8'h50, 8'h32); cyc(6); check(fl, 9'h000);
        apb(1, `CTRL_OFS, 32'h1);
        apb(1, `CTRL_OFS, 32'h7);
        apb(0, `CTRL_OFS, 0);      check(d, 32'h1);
        cyc(6); check(fl, 9'h0BF);
        i_front.put(1, 8'h1E); i_front.put(3, 8'h05);
        cyc(6); check(fl, 9'h035);
        i_front.put(1, 8'h50); i_front.put(0, 8'h3A);
        cyc(6); check(fl[0], 1'b1);
        i_front.put(0, 8'h38); cyc(6); check(fl[0], 1'b0);
        line(8'h00, 8'h00); cyc(6); check(fl, 9'h040);
        i_front.put(4, 8'h32); cyc(6); check(fl, 9'h010);
        line(8'h50, 8'h32); inh <= 1'b1; cyc(6); check(fl, 9'h000);
        inh <= 1'b0;
        done("detector");
        cyc(1900); apb(0, `STATUS_OFS, 0); check(d[10:8], 3'b001);
        cyc(150);  apb(0, `STATUS_OFS, 0); check(d[10:8], 3'b010);
        // Each mode trips on its own condition and releases after about 200 ms.
        for (int m = 0; m < 3; m++) begin
            apb(1, `CTRL_OFS, 32'(1 | (m << 1)));
            if (m == 2) begin
                i_front.put(9, 8'h1E); i_front.put(6, 8'h1E);
                cyc(60); check(fl[8], 1'b0);
            end
            i_front.put(m == 1 ? 8 : 6, 8'h1E); i_front.put(9, 8'h00);
            cyc(30); check(fl[8], 1'b0);
            cyc(30); check(fl[8], 1'b1);
            i_front.put(6, 8'h00); i_front.put(8, 8'h00);
            cyc(1900); check(fl[8], 1'b1);
            cyc(200);  check(fl[8], 1'b0);
        end
        done("modes");
        i_front.put(6, 8'h1E); cyc(1200); check(fl[8], 1'b1);
        line(8'h00, 8'h00); cyc(500); check(fl[8], 1'b1);
        apb(0, `STATUS_OFS, 0); check(d[11], 1'b1);
        line(8'h50, 8'h32); i_front.put(6, 8'h00);
        cyc(2100); check(fl[8], 1'b0);
        i_front.put(6, 8'h1E); cyc(60); check(fl[8], 1'b1);
        cyc(400); line(8'h00, 8'h00); cyc(6); check(fl[8], 1'b0);
        apb(0, `STATUS_OFS, 0); check(d[11:8], 4'h1);
        done("latch");
        i_front.put(6, 8'h00); line(8'h50, 8'h32); cyc(2050);
        apb(0, `STATUS_OFS, 0); check(d[10:8], 3'b010);
        line(8'h00, 8'h00); cyc(6);
        apb(0, `STATUS_OFS, 0); check(d[10:8], 3'b001);
        line(8'h50, 8'h32); cyc(2050);
        apb(0, `STATUS_OFS, 0); check(d[10:8], 3'b010);
        inh <= 1'b1; cyc(6);
        apb(0, `STATUS_OFS, 0); check(d[10:8], 3'b001);
        done("arming");
        tally_and_finish();
    end
endmodule // tb
`default_nettype wire
